// file: common/swl_defs.svh
// Timing and field constants for the single-wire bit link.
// Function
// - Bytes travel most significant bit first.
// - Eight bit frames, then ninth acknowledge frame.
// - Upper address nibble carries the command opcode.
// - Device pulls low on discovery request edge.
// - Device holds discovery acknowledge then releases.
// - High speed after reset; standard only on command.
// - While busy the device ignores frames; only a discharge low resets it.
// - Each frame stays inside the speed's limits.
// - Frame timing starts on every falling edge.
// - Sample once between longest one and shortest zero.
// - Low at sample is zero, high is one.
// - Zero frame is acknowledge, one frame not.
// - Discovery acknowledge lasts 8 to 24 us.
`ifndef SWL_DEFS_SVH
`define SWL_DEFS_SVH

`define SWL_CLK_MHZ 10
`define SWL_US2CYC(us) ((us) * `SWL_CLK_MHZ)
`define SWL_CNT_W 16
`define SWL_CNT_ONE 16'h0001
`define SWL_CNT_MAX 16'hFFFF
`define SWL_BITS_PER_BYTE 4'h8
`define SWL_OPC_HI 7
`define SWL_OPC_LO 4

`define SWL_HS_SAMPLE_US 4
`define SWL_STD_SAMPLE_US 16
`define SWL_HS_HOLD0_US 4
`define SWL_STD_HOLD0_US 16
`define SWL_DACK_US 16
`define SWL_DSCHG_US 150
`define SWL_HS_RESET_US 48
`define SWL_STD_RESET_US 480
`define SWL_HS_BITMAX_US 25
`define SWL_STD_BITMAX_US 100
`define SWL_HS_START_US 150
`define SWL_STD_START_US 600

`endif

// file: common/swl_pkg.sv
// Types shared by the single-wire bit link modules.
`default_nettype none
package swl_pkg;
    // Link phase after reset: wait for discovery, acknowledge it, then run frames.
    typedef enum logic [1:0] {
        M_DISC = 2'b00,
        M_DACK = 2'b01,
        M_RUN = 2'b10
    } swl_mode_t;

    // One received byte and whether it is the first byte after a start.
    typedef struct packed {
        logic first;
        logic [7:0] data;
    } swl_rx_t;

    // Line timer state.
    typedef struct packed {
        logic prev;
        logic [15:0] low_cnt;
        logic [15:0] high_cnt;
    } swl_tmr_st_t;

    // Frame engine state.
    typedef struct packed {
        swl_mode_t mode;
        logic hs;
        logic started;
        logic first_pend;
        logic drive;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        swl_rx_t rx;
        logic rx_valid;
        logic start_seen;
        logic reset_seen;
        logic frame_err;
    } swl_link_st_t;
endpackage
`default_nettype wire

// file: hw/swl_timer.sv
// Line timer that measures low and high durations of the shared wire.
`include "swl_defs.svh"
`default_nettype none
module swl_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line,
    output logic fell,
    output logic rose,
    output var logic [`SWL_CNT_W-1:0] low_cnt,
    output var logic [`SWL_CNT_W-1:0] high_cnt
);
    swl_pkg::swl_tmr_st_t s_reg; // Registered timer state.
    swl_pkg::swl_tmr_st_t s_next; // Next timer state.

    // Edges are seen against the previous sample of the line.
    assign fell = s_reg.prev & ~line;
    assign rose = ~s_reg.prev & line;
    assign low_cnt = s_reg.low_cnt;
    assign high_cnt = s_reg.high_cnt;

    // Both counters saturate so a long idle never wraps into a false match.
    always_comb begin
        s_next = s_reg;
        s_next.prev = line;
        if (fell) begin
            s_next.low_cnt = `SWL_CNT_ONE;
        end else if (s_reg.low_cnt != `SWL_CNT_MAX) begin
            s_next.low_cnt = s_reg.low_cnt + `SWL_CNT_ONE;
        end
        if (rose) begin
            s_next.high_cnt = `SWL_CNT_ONE;
        end else if (s_reg.high_cnt != `SWL_CNT_MAX) begin
            s_next.high_cnt = s_reg.high_cnt + `SWL_CNT_ONE;
        end
    end

    // The line idles high through the pull-up, so reset assumes high.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{prev: 1'b1, low_cnt: `SWL_CNT_MAX, high_cnt: `SWL_CNT_MAX};
        end else begin
            s_reg <= s_next;
        end
    end
endmodule
`default_nettype wire

// file: hw/swl_link.sv
// Device-side bit frame engine of the single-wire serial EEPROM link.
`include "swl_defs.svh"
`default_nettype none
module swl_link #(
    parameter logic [15:0] RESET_STD_CYC = 16'(`SWL_US2CYC(`SWL_STD_RESET_US)),
    parameter logic [15:0] START_STD_CYC = 16'(`SWL_US2CYC(`SWL_STD_START_US))
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic SIO_IN,
    output logic SIO_OUT,
    output logic SIO_OE,
    input wire logic BUSY,
    input wire logic TX_ACK,
    input wire logic SET_STD,
    input wire logic SET_HS,
    output swl_pkg::swl_rx_t RX,
    output logic RX_VALID,
    output logic [3:0] RX_OPCODE,
    output logic START_SEEN,
    output logic RESET_SEEN,
    output logic FRAME_ERR,
    output logic HIGH_SPEED
);
    swl_pkg::swl_link_st_t s_reg; // Registered engine state.
    swl_pkg::swl_link_st_t s_next; // Next engine state.
    logic fell; // Line fell this cycle.
    logic [15:0] low_cnt; // Cycles since the last falling edge.
    logic [15:0] high_cnt; // Cycles since the last rising edge.
    logic [15:0] sample_len; // Sample point of an input frame.
    logic [15:0] hold_len; // Length of our acknowledge low.
    logic [15:0] bitmax_len; // Longest legal frame.
    logic [15:0] start_len; // High time that forms a start.
    logic [15:0] rst_len; // Low time that resets the device.
    logic rst_hit; // A reset low has just completed.
    logic sample_hit; // Sample point of a data or acknowledge frame reached.
    logic ack_req; // Ninth frame has begun.

    // Every duration on the wire is taken from this one timer.
    swl_timer u_timer (
        .clk(MCLK),
        .rst_n(ARST_N),
        .line(SIO_IN),
        .fell(fell),
        .rose(),
        .low_cnt(low_cnt),
        .high_cnt(high_cnt)
    );

    // Speed-dependent limits; the sample point sits midway between a long one and a short zero.
    always_comb begin
        sample_len = s_reg.hs ? 16'(`SWL_US2CYC(`SWL_HS_SAMPLE_US))
                              : 16'(`SWL_US2CYC(`SWL_STD_SAMPLE_US));
        hold_len = s_reg.hs ? 16'(`SWL_US2CYC(`SWL_HS_HOLD0_US))
                            : 16'(`SWL_US2CYC(`SWL_STD_HOLD0_US));
        bitmax_len = s_reg.hs ? 16'(`SWL_US2CYC(`SWL_HS_BITMAX_US))
                              : 16'(`SWL_US2CYC(`SWL_STD_BITMAX_US));
        start_len = s_reg.hs ? 16'(`SWL_US2CYC(`SWL_HS_START_US)) : START_STD_CYC;
        if (BUSY) begin
            rst_len = 16'(`SWL_US2CYC(`SWL_DSCHG_US));
        end else if (s_reg.hs) begin
            rst_len = 16'(`SWL_US2CYC(`SWL_HS_RESET_US));
        end else begin
            rst_len = RESET_STD_CYC;
        end
    end

    // Our own drive never lasts long enough to look like a reset.
    assign rst_hit = !SIO_IN && !s_reg.drive && (low_cnt == rst_len);
    assign sample_hit = !BUSY && !rst_hit && (s_reg.mode == swl_pkg::M_RUN) && s_reg.started
                        && (low_cnt == sample_len);
    assign ack_req = !BUSY && !rst_hit && (s_reg.mode == swl_pkg::M_RUN) && s_reg.started
                     && fell && (s_reg.bit_cnt == `SWL_BITS_PER_BYTE);

    // Frame engine: reset detection first, then only a drive release while busy, then the link phase.
    always_comb begin
        s_next = s_reg;
        s_next.rx_valid = 1'b0;
        s_next.start_seen = 1'b0;
        s_next.reset_seen = 1'b0;
        s_next.frame_err = 1'b0;
        // Speed changes on an explicit command from the command layer, or on a completed reset low.
        if (SET_STD) begin
            s_next.hs = 1'b0;
        end
        if (SET_HS) begin
            s_next.hs = 1'b1;
        end
        if (rst_hit) begin
            // A completed reset low always returns to high speed and awaits discovery.
            s_next.mode = swl_pkg::M_DISC;
            s_next.hs = 1'b1;
            s_next.started = 1'b0;
            s_next.bit_cnt = 4'h0;
            s_next.drive = 1'b0;
            s_next.reset_seen = 1'b1;
        end else if (BUSY) begin
            // No frame is measured while a command executes; only a discharge reaches us.
            s_next.drive = 1'b0;
        end else begin
            case (s_reg.mode)
                swl_pkg::M_DISC: begin
                    // The first fall after reset is the discovery request.
                    if (fell) begin
                        s_next.drive = 1'b1;
                        s_next.mode = swl_pkg::M_DACK;
                    end
                end
                swl_pkg::M_DACK: begin
                    // Hold the acknowledge from the request edge, then hand back to the pull-up.
                    if (low_cnt == 16'(`SWL_US2CYC(`SWL_DACK_US))) begin
                        s_next.drive = 1'b0;
                        s_next.mode = swl_pkg::M_RUN;
                    end
                end
                swl_pkg::M_RUN: begin
                    // A long enough high is a start or stop and realigns the byte.
                    if (SIO_IN && (high_cnt == start_len)) begin
                        s_next.started = 1'b1;
                        s_next.first_pend = 1'b1;
                        s_next.bit_cnt = 4'h0;
                        s_next.start_seen = 1'b1;
                    end
                    if (s_reg.started) begin
                        // A zero frame is our acknowledge, so we pull low when TX_ACK asks.
                        if (ack_req && TX_ACK) begin
                            s_next.drive = 1'b1;
                        end
                        if (s_reg.drive && (low_cnt == hold_len)) begin
                            s_next.drive = 1'b0;
                        end
                        if (sample_hit) begin
                            if (s_reg.bit_cnt == `SWL_BITS_PER_BYTE) begin
                                // Ninth frame done; the next fall opens a new byte.
                                s_next.bit_cnt = 4'h0;
                            end else begin
                                // Low means zero, released high means one.
                                s_next.shift = {s_reg.shift[6:0], SIO_IN};
                                s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                                if (s_reg.bit_cnt == `SWL_BITS_PER_BYTE - 4'h1) begin
                                    s_next.rx_valid = 1'b1;
                                    s_next.rx.data = {s_reg.shift[6:0], SIO_IN};
                                    s_next.rx.first = s_reg.first_pend;
                                    s_next.first_pend = 1'b0;
                                end
                            end
                        end
                        // A frame that outlives its limit mid-byte waits for a new start.
                        if (SIO_IN && (low_cnt == bitmax_len) && (s_reg.bit_cnt != 4'h0)) begin
                            s_next.frame_err = 1'b1;
                            s_next.started = 1'b0;
                            s_next.bit_cnt = 4'h0;
                        end
                    end
                end
                default: begin
                    s_next.mode = swl_pkg::M_DISC;
                    s_next.drive = 1'b0;
                end
            endcase
        end
    end

    // Power-up behaves as a reset: high speed, waiting for a discovery request.
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s_reg <= '{mode: swl_pkg::M_DISC, hs: 1'b1, rx: '0, shift: 8'h00,
                       bit_cnt: 4'h0, default: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    // The pin only ever pulls low; the pull-up makes the high level.
    assign SIO_OUT = 1'b0;
    assign SIO_OE = s_reg.drive;
    assign RX = s_reg.rx;
    assign RX_VALID = s_reg.rx_valid;
    // The first byte after a start is the address; its top nibble is the opcode.
    assign RX_OPCODE = s_reg.rx.data[`SWL_OPC_HI:`SWL_OPC_LO];
    assign START_SEEN = s_reg.start_seen;
    assign RESET_SEEN = s_reg.reset_seen;
    assign FRAME_ERR = s_reg.frame_err;
    assign HIGH_SPEED = s_reg.hs;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!ARST_N);

    sequence disc_req_s;
        (s_reg.mode == swl_pkg::M_DISC) && fell && !BUSY && !rst_hit;
    endsequence

    sequence dack_start_s;
        $rose(SIO_OE) && (s_reg.mode == swl_pkg::M_DACK);
    endsequence

    chk_disc_drive_low: assert property (disc_req_s |=> SIO_OE)
        else $error("discovery request not answered by a low drive");
    chk_dack_length: assert property (
        dack_start_s and (!BUSY)[*1] |-> ##159 SIO_OE ##1 !SIO_OE)
        else $error("discovery acknowledge has the wrong length");
    chk_speed_after_reset: assert property (rst_hit |=> HIGH_SPEED)
        else $error("device not in high speed after a reset");
    chk_speed_steady: assert property (
        !SET_STD && !SET_HS && !rst_hit |=> $stable(HIGH_SPEED))
        else $error("speed changed without a command");
    chk_busy_quiet: assert property (BUSY && !rst_hit |=> !RX_VALID && !SIO_OE)
        else $error("line acted on while busy");
    chk_sample_value: assert property (
        sample_hit && (s_reg.bit_cnt != 4'h8) |=> s_reg.shift[0] == $past(SIO_IN))
        else $error("sampled bit does not match the line");
    chk_byte_nine: assert property (RX_VALID |-> s_reg.bit_cnt == 4'h8 ##1 !RX_VALID)
        else $error("byte delivered at the wrong bit count");
    chk_ack_drive: assert property (ack_req && TX_ACK |=> SIO_OE)
        else $error("acknowledge not driven low");
    chk_frame_timer: assert property (fell |=> low_cnt == 16'h0001)
        else $error("frame timer not restarted on a fall");
endmodule
`default_nettype wire

// file: tb/swl_host_model.sv
// Host controller model that frames bits on the shared wire.
`default_nettype none
module swl_host_model (
    input wire logic clk,
    input wire logic dev_oe,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ns;
    // High while the host pulls the wire low.
    logic host_low = 1'b0;
    // Wire level seen at the host's strobe point of the last frame.
    logic smp = 1'b1;
    // Open drain with a pull-up: the wire is high unless some party pulls it low.
    assign line = ~(host_low | dev_oe);
    // Every frame with a nonzero low_c begins with a host fall, and the host lets go after low_c cycles.
    // The host low is never stretched, though the device can hold the wire low past it; each frame still lasts len_c cycles.
    task automatic frame(input int low_c, input int len_c, input int smp_c);
        for (int i = 0; i < len_c; i++) begin
            @(posedge clk);
            #10;
            host_low = (i < low_c);
            if (i == smp_c) smp = line;
        end
    endtask
    // The most significant bit goes out first; a zero is a long low and a one a short low.
    // The callers pass lengths inside the speed's limits.
    task automatic send_byte(input logic [7:0] b, input int z, input int o, input int n);
        for (int i = 7; i >= 0; i--) frame(b[i] ? o : z, n, 0);
    endtask
endmodule
`default_nettype wire

// file: tb/test_swl_link.sv
// Self-checking bench for the device-side bit frame engine.
`default_nettype none
module test_swl_link;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK = 1'b0;
    logic ARST_N = 1'b0;
    logic BUSY = 1'b0;
    logic TX_ACK = 1'b0;
    logic SET_STD = 1'b0;
    logic SET_HS = 1'b0;
    logic SIO_IN, SIO_OUT, SIO_OE, RX_VALID, START_SEEN, RESET_SEEN, FRAME_ERR, HIGH_SPEED;
    logic [3:0] RX_OPCODE;
    swl_pkg::swl_rx_t RX;
    // Copies of the last received byte, taken at its valid pulse.
    swl_pkg::swl_rx_t rx_last;
    logic [3:0] op_last;
    int n_fail = 0;
    int check_count = 0;
    int rx_cnt = 0;
    int oe_cnt = 0;
    int fe_cnt = 0;
    int rs_cnt = 0;
    int ss_cnt = 0;
    always #50 MCLK = ~MCLK;
    // Short standard-speed counts keep the run brief.
    // The start still outlasts the high part of any frame, else every frame would realign.
    // The reset stays above the high-speed one, so one long low is seen as one reset.
    swl_link #(.RESET_STD_CYC(16'h0258), .START_STD_CYC(16'h04B0)) uut (
        .MCLK(MCLK), .ARST_N(ARST_N), .SIO_IN(SIO_IN), .SIO_OUT(SIO_OUT), .SIO_OE(SIO_OE),
        .BUSY(BUSY), .TX_ACK(TX_ACK), .SET_STD(SET_STD), .SET_HS(SET_HS), .RX(RX),
        .RX_VALID(RX_VALID), .RX_OPCODE(RX_OPCODE), .START_SEEN(START_SEEN),
        .RESET_SEEN(RESET_SEEN), .FRAME_ERR(FRAME_ERR), .HIGH_SPEED(HIGH_SPEED)
    );
    swl_host_model host (.clk(MCLK), .dev_oe(SIO_OE), .line(SIO_IN));
    // Event counters; pulses last one cycle, so every edge is looked at.
    always @(posedge MCLK) begin
        if (SIO_OE === 1'b1) oe_cnt++;
        if (FRAME_ERR === 1'b1) fe_cnt++;
        if (RESET_SEEN === 1'b1) rs_cnt++;
        if (START_SEEN === 1'b1) ss_cnt++;
        if (RX_VALID === 1'b1) begin
            rx_cnt++;
            rx_last = RX;
            op_last = RX_OPCODE;
        end
    end
    task automatic expect_ok(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // A one-cycle pulse on a speed request input.
    task automatic pulse_speed(input logic to_std);
        @(posedge MCLK);
        #10;
        if (to_std) SET_STD = 1'b1;
        else SET_HS = 1'b1;
        @(posedge MCLK);
        #10;
        SET_STD = 1'b0;
        SET_HS = 1'b0;
    endtask
    // Recovery high, then a short request; the device answers low for 16 us.
    task automatic do_discovery;
        oe_cnt = 0;
        host.frame(0, 100, 0);
        host.frame(15, 300, 40);
        expect_ok(host.smp === 1'b0, "no presence");
        expect_ok(oe_cnt === 160, "discovery low length");
        expect_ok(SIO_OUT === 1'b0 && SIO_OE === 1'b0, "pin not released");
    endtask
    // Two high-speed bytes at the boundary low times, acknowledged then refused.
    task automatic hs_bytes;
        int n0;
        ss_cnt = 0;
        host.frame(0, 1600, 0);
        expect_ok(ss_cnt === 1, "start missing");
        n0 = rx_cnt;
        TX_ACK = 1'b1;
        host.send_byte(8'hD5, 60, 20, 200);
        host.frame(15, 200, 25);
        expect_ok(host.smp === 1'b0, "ack missing");
        expect_ok(rx_last === {1'b1, 8'hD5} && rx_cnt === n0 + 1, "byte one");
        expect_ok(op_last === 4'hD, "opcode");
        TX_ACK = 1'b0;
        host.send_byte(8'h3A, 60, 20, 200);
        host.frame(15, 200, 25);
        expect_ok(host.smp === 1'b1, "nack missing");
        expect_ok(rx_last === {1'b0, 8'h3A}, "byte two");
    endtask
    // Standard speed moves the sample point out to 16 us.
    task automatic std_byte;
        pulse_speed(1'b1);
        expect_ok(HIGH_SPEED === 1'b0, "still high speed");
        TX_ACK = 1'b1;
        host.send_byte(8'h96, 240, 80, 800);
        host.frame(50, 800, 100);
        expect_ok(host.smp === 1'b0, "std ack missing");
        expect_ok(rx_last === {1'b0, 8'h96}, "std byte");
        pulse_speed(1'b0);
        expect_ok(HIGH_SPEED === 1'b1, "speed not restored");
    endtask
    // A frame that outlives 25 us mid-byte stops decoding until a new start.
    task automatic frame_error;
        int n0;
        n0 = rx_cnt;
        fe_cnt = 0;
        for (int i = 0; i < 3; i++) host.frame(60, 200, 0);
        host.frame(15, 400, 0);
        expect_ok(fe_cnt === 1, "no frame error");
        host.send_byte(8'h5A, 60, 20, 200);
        host.frame(15, 200, 0);
        expect_ok(rx_cnt === n0, "decoded without start");
        host.frame(0, 1600, 0);
        host.send_byte(8'h5A, 60, 20, 200);
        host.frame(15, 200, 0);
        expect_ok(rx_last === {1'b1, 8'h5A} && rx_cnt === n0 + 1, "restart byte");
    endtask
    // Busy ignores frames; only a discharge low resets; a wire reset restores high speed.
    task automatic busy_and_resets;
        int n0;
        n0 = rx_cnt;
        rs_cnt = 0;
        host.frame(0, 1600, 0);
        BUSY = 1'b1;
        host.send_byte(8'hC3, 60, 20, 200);
        host.frame(15, 200, 0);
        expect_ok(rx_cnt === n0, "busy byte taken");
        host.frame(1600, 1601, 0);
        expect_ok(rs_cnt === 1, "discharge reset missed");
        BUSY = 1'b0;
        do_discovery();
        pulse_speed(1'b1);
        host.frame(650, 651, 0);
        expect_ok(rs_cnt === 2, "idle reset missed");
        expect_ok(HIGH_SPEED === 1'b1, "not high speed after reset");
    endtask
    initial begin
        repeat (3) @(posedge MCLK);
        #10;
        ARST_N = 1'b1;
        do_discovery();
        hs_bytes();
        std_byte();
        frame_error();
        busy_and_resets();
        tally_and_finish();
    end
    // Guard against a hang.
    initial begin
        repeat (100000) @(posedge MCLK);
        n_fail++;
        $display("[ERR] %0t timeout", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
